// ---- core/eisb_irq_status.v ----
`timescale 1ns/1ps
`include "eisb_defines.vh"

module eisb_irq_status (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output wire [31:0] reg_rdata,
	// Transmit engine
	input wire tx_stop_request,
	input wire tx_halted,
	input wire tx_buffer_loaded,
	input wire completion_notify_mark,
	input wire tx_error,
	// Receive engine
	input wire rx_halted,
	input wire rx_error,
	input wire rx_frame_end,
	input wire [13:0] rx_frame_len,
	input wire rx_frame_dropped,
	input wire [31:0] rx_drop_count,
	// Receive data transfer
	input wire [11:0] rx_transfer_count,
	input wire rx_dword_read,
	// Transmit data FIFO
	input wire tx_data_full,
	input wire tx_data_write,
	input wire [7:0] tx_free_blocks,
	input wire [7:0] tx_space_level,
	// Status FIFOs
	input wire tx_status_overflow,
	input wire tx_status_full,
	input wire [7:0] tx_status_used,
	input wire [7:0] tx_status_level,
	input wire rx_status_full,
	input wire [7:0] rx_status_used,
	input wire [7:0] rx_status_level,
	// Timer, transceiver, power, pins
	input wire [15:0] timer_value,
	input wire transceiver_event,
	input wire power_event,
	input wire sleep_request,
	input wire [2:0] pin_events,
	// Interrupt and power outputs
	output wire irq_master,
	output wire power_irq,
	output wire low_power
);

// ****************************************
// Declarations
// ****************************************
reg [31:0] rdata_r;
reg [31:0] rdata_nxt;
reg [31:0] enable_r;
reg [31:0] enable_nxt;
reg irq_master_r;
reg irq_master_nxt;
reg power_irq_r;
reg power_irq_nxt;
reg low_power_r;
reg low_power_nxt;
reg [6:0] level_prev_r;
reg [31:0] drop_prev_r;
reg [15:0] timer_prev_r;
reg prev_valid_r;
reg xcvr_r;
reg [6:0] level_prev_nxt;
reg [31:0] drop_prev_nxt;
reg [15:0] timer_prev_nxt;
reg prev_valid_nxt;
reg xcvr_nxt;
wire [6:0] level_now;
wire [6:0] level_rise;
wire [31:0] set_vec;
wire [31:0] clr_vec;
wire [31:0] flags;
wire [31:0] enabled_flags;
reg sts_hit;
reg en_hit;
reg cfg_hit;
reg bt_hit;
wire sts_clear_wr;
wire en_wr;
wire wake_wr;

// ****************************************
// Address decode
// ****************************************
// Exact eight-bit compare; a partial decode would let a write to a
// neighbouring offset clear flags by accident.
always @* begin
	sts_hit = 1'h0;
	en_hit = 1'h0;
	cfg_hit = 1'h0;
	bt_hit = 1'h0;
	case (reg_addr)
		`EISB_STS_OFS: begin
			sts_hit = 1'h1;
		end
		`EISB_EN_OFS: begin
			en_hit = 1'h1;
		end
		`EISB_CFG_OFS: begin
			cfg_hit = 1'h1;
		end
		`EISB_BYTE_TEST_OFS: begin
			bt_hit = 1'h1;
		end
		default: begin
			sts_hit = 1'h0;
		end
	endcase
end

assign sts_clear_wr = reg_wr & sts_hit;
assign en_wr = reg_wr & en_hit;
assign wake_wr = reg_wr & bt_hit;

// ****************************************
// Level conditions and edge detect
// ****************************************
// Level sources are turned into one-shot events so that a clear
// sticks while the condition lasts; it sets again on the next rise.
assign level_now[0] = tx_stop_request & tx_halted;
assign level_now[1] = rx_halted;
assign level_now[2] = tx_free_blocks > tx_space_level;
assign level_now[3] = tx_status_full;
assign level_now[4] = tx_status_used > tx_status_level;
assign level_now[5] = rx_status_full;
assign level_now[6] = rx_status_used > rx_status_level;
assign level_rise = level_now & ~level_prev_r;

always @* begin
	level_prev_nxt = level_now;
	drop_prev_nxt = rx_drop_count;
	timer_prev_nxt = timer_value;
	prev_valid_nxt = 1'h1;
	xcvr_nxt = transceiver_event;
end

always @(posedge clk) begin
	if (!rstn) begin
		level_prev_r <= 7'h00;
		drop_prev_r <= `EISB_RESET_ZERO;
		timer_prev_r <= `EISB_TIMER_ZERO;
		prev_valid_r <= 1'h0;
		xcvr_r <= 1'h0;
	end else begin
		level_prev_r <= level_prev_nxt;
		drop_prev_r <= drop_prev_nxt;
		timer_prev_r <= timer_prev_nxt;
		prev_valid_r <= prev_valid_nxt;
		xcvr_r <= xcvr_nxt;
	end
end

// ****************************************
// Event sources
// ****************************************
// Sources other than the software flag are never gated by the enable mask
// Software flag is set while its enable bit is high and held until cleared
assign set_vec[`EISB_B_SW] = enable_r[`EISB_B_SW];
assign set_vec[30:26] = 5'h00;
// Stop requested and transmitter at rest
assign set_vec[`EISB_B_TXSTOP] = level_rise[0];
// Receiver at rest
assign set_vec[`EISB_B_RXSTOP] = level_rise[1];
// Drop counter steps into its upper half
assign set_vec[`EISB_B_DROPHALF] = prev_valid_r & (drop_prev_r == `EISB_DROP_BEFORE) &
	(rx_drop_count == `EISB_DROP_HALF);
assign set_vec[22] = 1'h0;
// Marked buffer fully loaded
assign set_vec[`EISB_B_TXDONE] = tx_buffer_loaded & completion_notify_mark;
// Last programmed dword read out
assign set_vec[`EISB_B_RXDRAIN] = rx_dword_read & (rx_transfer_count == `EISB_CNT_LAST);
// Timer passes zero to all ones
assign set_vec[`EISB_B_TIMER] = prev_valid_r & (timer_prev_r == `EISB_TIMER_ZERO) &
	(timer_value == `EISB_TIMER_WRAP);
// Mirror only; not held here
assign set_vec[`EISB_B_XCVR] = 1'h0;
// Power event sets regardless of the wake pin
assign set_vec[`EISB_B_PWR] = power_event;
// Transmit status overflow
assign set_vec[`EISB_B_TSOVF] = tx_status_overflow;
// Oversize frame at its end
assign set_vec[`EISB_B_OVERSIZE] = rx_frame_end & (rx_frame_len > `EISB_RX_MAX_LEN);
// Receive and transmit errors
assign set_vec[`EISB_B_RXERR] = rx_error;
assign set_vec[`EISB_B_TXERR] = tx_error;
assign set_vec[12:11] = 2'h0;
// Write while the data FIFO is already full
assign set_vec[`EISB_B_TDOVR] = tx_data_write & tx_data_full;
// Free space above threshold
assign set_vec[`EISB_B_TXSPACE] = level_rise[2];
// Status FIFOs become full
assign set_vec[`EISB_B_TSFULL] = level_rise[3];
assign set_vec[`EISB_B_RSFULL] = level_rise[5];
// Transmit status level
assign set_vec[`EISB_B_TSLEVEL] = level_rise[4];
// Every dropped frame
assign set_vec[`EISB_B_DROP] = rx_frame_dropped;
assign set_vec[5] = 1'h0;
// Receive status level
assign set_vec[`EISB_B_RSLEVEL] = level_rise[6];
// One flag per pin
assign set_vec[2:0] = pin_events;

// ****************************************
// Host clear
// ****************************************
// Zero bits and reserved bits are left alone
assign clr_vec = {32{sts_clear_wr}} & reg_wdata & `EISB_CLEAR_MASK;

// ****************************************
// Flag bank
// ****************************************
genvar gi;
generate
	for (gi = 0; gi < 32; gi = gi + 1) begin : g_flag
		if (((`EISB_CLEAR_MASK >> gi) & 1) == 1) begin : g_held
			eisb_flag_bit u_bit (
				.clk(clk),
				.rstn(rstn),
				.set(set_vec[gi]),
				.clr(clr_vec[gi]),
				.q(flags[gi])
			);
		end else if (gi == `EISB_B_XCVR) begin : g_mirror
			// Host writes cannot touch it; cleared at the source
			assign flags[gi] = xcvr_r;
		end else begin : g_resv
			// Reserved reads as zero
			assign flags[gi] = 1'h0;
		end
	end
endgenerate

// ****************************************
// Enable mask
// ****************************************
always @* begin
	enable_nxt = enable_r;
	// Reserved enable bits are dropped so they read back as zero
	if (en_wr) begin
		enable_nxt = reg_wdata & `EISB_IMPL_MASK;
	end
end

always @(posedge clk) begin
	if (!rstn) begin
		enable_r <= `EISB_RESET_ZERO;
	end else begin
		enable_r <= enable_nxt;
	end
end

// ****************************************
// Interrupt lines
// ****************************************
// The master line trails the flags by one cycle, so a flag cleared
// by the host keeps the line up for that one extra cycle.
assign enabled_flags = flags & enable_r;

always @* begin
	// Any enabled flag drives the master line
	irq_master_nxt = |enabled_flags;
	// Separate path, never held off by a deassertion timer
	power_irq_nxt = enabled_flags[`EISB_B_PWR];
end

always @(posedge clk) begin
	if (!rstn) begin
		irq_master_r <= 1'h0;
		power_irq_r <= 1'h0;
	end else begin
		irq_master_r <= irq_master_nxt;
		power_irq_r <= power_irq_nxt;
	end
end

// ****************************************
// Low power state
// ****************************************
// Power events and the wake pin are deliberately ignored here; a
// host that forgets the byte-test write leaves the device asleep.
always @* begin
	low_power_nxt = low_power_r;
	if (wake_wr) begin
		low_power_nxt = 1'h0;
	end else if (sleep_request) begin
		low_power_nxt = 1'h1;
	end
end

always @(posedge clk) begin
	if (!rstn) begin
		low_power_r <= 1'h0;
	end else begin
		low_power_r <= low_power_nxt;
	end
end

// ****************************************
// Read data
// ****************************************
// Read data is registered, so it shows the flags as they stood in
// the strobe cycle; unmapped offsets answer zero.
always @* begin
	rdata_nxt = `EISB_RESET_ZERO;
	if (reg_rd) begin
		if (sts_hit) begin
			rdata_nxt = flags;
		end else if (en_hit) begin
			rdata_nxt = enable_r;
		end else if (cfg_hit) begin
			rdata_nxt[`EISB_MASTER_POS] = irq_master_r;
		end else if (bt_hit) begin
			rdata_nxt = `EISB_BYTE_TEST_VAL;
		end
	end
end

always @(posedge clk) begin
	if (!rstn) begin
		rdata_r <= `EISB_RESET_ZERO;
	end else begin
		rdata_r <= rdata_nxt;
	end
end

// ****************************************
// Outputs
// ****************************************
assign reg_rdata = rdata_r;
assign irq_master = irq_master_r;
assign power_irq = power_irq_r;
assign low_power = low_power_r;

endmodule // eisb_irq_status

// ---- core/eisb_defines.vh ----
// Function
// - Writing one to a flag clears it
// - Bit 31 set while software enable high
// - Bit 25 set when stop requested, transmitter halted
// - Bit 24 set when receiver halted
// - Bit 23 set as drop counter enters 80000000h
// - Bit 21 set when marked buffer loaded
// - Bit 20 set when transfer count drained
// - Bit 19 set when timer wraps to FFFFh
// - Bit 18 mirrors transceiver event, read-only
// - Bit 17 power event, independent of wake pin
// - Only a byte-test write ends low power
// - Power event interrupt bypasses hold-off interval
// - Bit 16 set on transmit status overflow
// - Bit 15 set on frame above 2048 bytes
// - Bits 14, 13 set on receive, transmit error
// - Bit 10 set on write into full FIFO
// - Bit 9 set when free space exceeds threshold
// - Bits 8, 4 set when status FIFOs full
// - Bit 7 set on transmit status level
// - Bit 3 set on receive status level
// - Bit 6 set on each dropped frame
// - Bits 2 to 0 set by pin events
// - Flags other than bit 31 update whatever the enable mask says
// - Master line high on any enabled flag
`ifndef EISB_DEFINES_VH
`define EISB_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define EISB_CFG_OFS 8'h54
`define EISB_STS_OFS 8'h58
`define EISB_EN_OFS 8'h5C
`define EISB_BYTE_TEST_OFS 8'h64

// ****************************************
// Values and masks
// ****************************************
`define EISB_BYTE_TEST_VAL 32'h87654321
`define EISB_CLEAR_MASK 32'h83BBE7DF
`define EISB_IMPL_MASK 32'h83BFE7DF
`define EISB_RESET_ZERO 32'h00000000
`define EISB_MASTER_POS 12

// ****************************************
// Flag positions
// ****************************************
`define EISB_B_SW 31
`define EISB_B_TXSTOP 25
`define EISB_B_RXSTOP 24
`define EISB_B_DROPHALF 23
`define EISB_B_TXDONE 21
`define EISB_B_RXDRAIN 20
`define EISB_B_TIMER 19
`define EISB_B_XCVR 18
`define EISB_B_PWR 17
`define EISB_B_TSOVF 16
`define EISB_B_OVERSIZE 15
`define EISB_B_RXERR 14
`define EISB_B_TXERR 13
`define EISB_B_TDOVR 10
`define EISB_B_TXSPACE 9
`define EISB_B_TSFULL 8
`define EISB_B_TSLEVEL 7
`define EISB_B_DROP 6
`define EISB_B_RSFULL 4
`define EISB_B_RSLEVEL 3

// ****************************************
// Event thresholds
// ****************************************
`define EISB_DROP_BEFORE 32'h7FFFFFFF
`define EISB_DROP_HALF 32'h80000000
`define EISB_TIMER_ZERO 16'h0000
`define EISB_TIMER_WRAP 16'hFFFF
`define EISB_RX_MAX_LEN 14'h0800
`define EISB_CNT_LAST 12'h001

`endif

// ---- core/eisb_flag_bit.v ----
`timescale 1ns/1ps
module eisb_flag_bit (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Event and host clear
	input wire set,
	input wire clr,
	// Held flag
	output wire q
);

reg flag_r;
wire flag_nxt;

// Hold until cleared; a fresh event beats the clear
assign flag_nxt = set | (flag_r & ~clr);

always @(posedge clk) begin
	if (!rstn) begin
		flag_r <= 1'h0;
	end else begin
		flag_r <= flag_nxt;
	end
end

assign q = flag_r;

endmodule // eisb_flag_bit

// ---- test/eisb_irq_status_properties.sv ----
`timescale 1ns/1ps
// ****
// Flag bank properties
// ****
module eisb_irq_status_properties (
	// Clock, reset, register port
	input wire clk,
	input wire rstn,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// Event sources
	input wire tx_error,
	input wire rx_error,
	input wire power_event,
	input wire transceiver_event,
	input wire [2:0] pin_events,
	// Outputs
	input wire irq_master,
	input wire power_irq,
	input wire low_power
);
	wire wake = reg_wr && reg_addr == 8'h64;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Status read with no clear taken just before it
	sequence sts_rd;
		reg_rd && reg_addr == 8'h58 && !$past(reg_wr) && $past(rstn, 2);
	endsequence
	pwr_flag_a: assert property (
		sts_rd ##0 $past(power_event, 2) |=> reg_rdata[17]) else $error("power flag missing");
	txerr_flag_a: assert property (
		sts_rd ##0 $past(tx_error, 2) |=> reg_rdata[13]) else $error("tx error flag missing");
	rxerr_flag_a: assert property (
		sts_rd ##0 $past(rx_error, 2) |=> reg_rdata[14]) else $error("rx error flag missing");
	pin_flags_a: assert property (
		sts_rd |=> (reg_rdata[2:0] & $past(pin_events, 3)) == $past(pin_events, 3)) else $error("pin flag missing");
	rsvd_zero_a: assert property (
		sts_rd |=> (reg_rdata & 32'h7C401820) == 32'h0) else $error("reserved bit set");
	xcvr_mirror_a: assert property (
		sts_rd ##0 $stable(transceiver_event) |=> reg_rdata[18] == $past(transceiver_event))
		else $error("transceiver bit wrong");
	low_hold_a: assert property (
		low_power && !wake |=> low_power) else $error("woke without byte test write");
	master_or_a: assert property (
		power_irq |-> irq_master) else $error("master line low with power irq");
endmodule // eisb_irq_status_properties

bind eisb_irq_status eisb_irq_status_properties eisb_irq_status_properties_inst (.*);

// ---- test/eisb_host_model.sv ----
`timescale 1ns/1ps
// ****
// Host model
// ****
module eisb_host_model (
	// Clock
	input wire clk,
	// Register port
	output reg [7:0] reg_addr,
	output reg [31:0] reg_wdata,
	output reg reg_wr,
	output reg reg_rd,
	input wire [31:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
	end
	// Ones acknowledge flags; any byte test write wakes the device
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
		// Idle lines carry junk so a stale value never passes for data
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task rd(input [7:0] a, output [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule // eisb_host_model

// ---- test/eisb_irq_status_tb.sv ----
`timescale 1ns/1ps
// ****
// Bench
// ****
module eisb_irq_status_tb;
	reg clk, rstn;
	wire [7:0] reg_addr;
	wire [31:0] reg_wdata, reg_rdata;
	wire reg_wr, reg_rd, irq_master, power_irq, low_power;
	reg tx_stop_request, tx_halted, tx_buffer_loaded, completion_notify_mark, tx_error, rx_halted, rx_error;
	reg rx_frame_end, rx_frame_dropped, rx_dword_read, tx_data_full, tx_data_write, tx_status_overflow;
	reg tx_status_full, rx_status_full, transceiver_event, power_event, sleep_request;
	reg [13:0] rx_frame_len;
	reg [31:0] rx_drop_count, seed, v, m;
	reg [11:0] rx_transfer_count;
	reg [15:0] timer_value;
	reg [7:0] tx_free_blocks, tx_space_level, tx_status_used, tx_status_level, rx_status_used, rx_status_level;
	reg [2:0] pin_events;
	int errors, checks_done, b;
	int bits[22] = '{31, 25, 24, 23, 21, 20, 19, 17, 16, 15, 14, 13, 10, 9, 8, 7, 6, 4, 3, 2, 1, 0};
	eisb_irq_status eisb_irq_status_inst (.*);
	eisb_host_model eisb_host_model_inst (.*);
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	function automatic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// A frame of exactly 2048 bytes must not count as oversize
	function automatic [31:0] rand_exp(input [31:0] r);
		return ((14'h07FF + r[4:3]) > 14'h0800 ? 32'h8000 : 32'h0) | r[2:0];
	endfunction
	task chk(input string n, input [31:0] e, input [31:0] s);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task rc(input string n, input [7:0] a, input [31:0] e);
		reg [31:0] d;
		eisb_host_model_inst.rd(a, d);
		chk(n, e, d);
	endtask
	task wr(input [7:0] a, input [31:0] d);
		eisb_host_model_inst.wr(a, d);
	endtask
	task idle();
		{tx_stop_request, tx_halted, tx_buffer_loaded, completion_notify_mark, tx_error, rx_halted} <= 6'h0;
		{rx_error, rx_frame_end, rx_frame_dropped, rx_dword_read, tx_data_full, tx_data_write} <= 6'h0;
		{tx_status_overflow, tx_status_full, rx_status_full, power_event, sleep_request, pin_events} <= 8'h0;
		rx_frame_len <= 14'h0;
		rx_drop_count <= 32'h0;
		rx_transfer_count <= 12'h003;
		timer_value <= 16'h1234;
		{tx_free_blocks, tx_space_level, tx_status_used, tx_status_level} <= 32'h10100505;
		{rx_status_used, rx_status_level} <= 16'h0505;
	endtask
	// Qualifiers go up a cycle early so the trigger gives a clean rising condition
	task fire(input int t);
		@(posedge clk);
		rx_drop_count <= 32'h7FFFFFFF;
		timer_value <= 16'h0000;
		rx_transfer_count <= 12'h001;
		rx_frame_len <= 14'h0801;
		{completion_notify_mark, tx_data_full, tx_stop_request} <= 3'h7;
		@(posedge clk);
		case (t)
			25: tx_halted <= 1'h1;
			24: rx_halted <= 1'h1;
			23: rx_drop_count <= 32'h80000000;
			21: tx_buffer_loaded <= 1'h1;
			20: rx_dword_read <= 1'h1;
			19: timer_value <= 16'hFFFF;
			17: power_event <= 1'h1;
			16: tx_status_overflow <= 1'h1;
			15: rx_frame_end <= 1'h1;
			14: rx_error <= 1'h1;
			13: tx_error <= 1'h1;
			10: tx_data_write <= 1'h1;
			9: tx_free_blocks <= 8'h11;
			8: tx_status_full <= 1'h1;
			7: tx_status_used <= 8'h06;
			6: rx_frame_dropped <= 1'h1;
			4: rx_status_full <= 1'h1;
			3: rx_status_used <= 8'h06;
			default: pin_events <= 3'h1 << t;
		endcase
		@(posedge clk);
		idle();
	endtask
	task give_verdict();
		$display("checks_done %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		give_verdict();
	end
	initial begin
		seed = 32'h000029B9;
		errors = 0;
		checks_done = 0;
		rstn = 1'h0;
		transceiver_event = 1'h0;
		idle();
		repeat (4) @(posedge clk);
		rstn <= 1'h1;
		rc("status", 8'h58, 32'h0);
		rc("byte_test", 8'h64, 32'h87654321);
		rc("unmapped", 8'h60, 32'h0);
		wr(8'h5C, 32'hFFFFFFFF);
		rc("enable", 8'h5C, 32'h83BFE7DF);
		wr(8'h58, 32'h80000000);
		rc("sw_hold", 8'h58, 32'h80000000);
		wr(8'h5C, 32'h0);
		wr(8'h58, 32'hFFFFFFFF);
		foreach (bits[i]) begin
			b = bits[i];
			m = 32'h1 << b;
			wr(8'h5C, b[0] ? m : 32'h0);
			fire(b);
			rc("flag", 8'h58, m);
			chk("irq_master", b[0], irq_master);
			chk("power_irq", b == 17, power_irq);
			rc("master_bit", 8'h54, b[0] ? 32'h1000 : 32'h0);
			wr(8'h5C, 32'h0);
			wr(8'h58, ~m);
			rc("held", 8'h58, m);
			wr(8'h58, m);
			rc("cleared", 8'h58, 32'h0);
		end
		repeat (20) begin
			v = xs();
			@(posedge clk);
			pin_events <= v[2:0];
			rx_frame_end <= 1'h1;
			rx_frame_len <= 14'h07FF + v[4:3];
			@(posedge clk);
			idle();
			rc("random", 8'h58, rand_exp(v));
			wr(8'h58, 32'hFFFFFFFF);
		end
		fork
			wr(8'h58, 32'h40);
			begin
				@(posedge clk);
				rx_frame_dropped <= 1'h1;
				@(posedge clk);
				rx_frame_dropped <= 1'h0;
			end
		join
		rc("set_wins", 8'h58, 32'h40);
		@(posedge clk);
		transceiver_event <= 1'h1;
		wr(8'h58, 32'h40040);
		rc("mirror", 8'h58, 32'h40000);
		@(posedge clk);
		transceiver_event <= 1'h0;
		rc("mirror", 8'h58, 32'h0);
		@(posedge clk);
		sleep_request <= 1'h1;
		@(posedge clk);
		sleep_request <= 1'h0;
		power_event <= 1'h1;
		@(posedge clk);
		power_event <= 1'h0;
		@(posedge clk);
		#1;
		chk("low_power", 32'h1, low_power);
		wr(8'h64, xs());
		#1;
		chk("low_power", 32'h0, low_power);
		@(posedge clk);
		sleep_request <= 1'h1;
		@(posedge clk);
		sleep_request <= 1'h0;
		fork
			wr(8'h64, 32'h0);
			begin
				@(posedge clk);
				sleep_request <= 1'h1;
				@(posedge clk);
				sleep_request <= 1'h0;
			end
		join
		#1;
		chk("wake_wins", 32'h0, low_power);
		give_verdict();
	end
endmodule // eisb_irq_status_tb
